// [hdl/ppr_pkg.sv]
// shared constants and carriers for the peripheral pin remap block
package ppr_pkg;
   // register port
   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] SERIAL_ROUTE_ADDR = 4'h0;
   localparam logic [3:0] IRQ_ROUTE_ADDR = 4'h1;
   localparam logic [7:0] SERIAL_ROUTE_RESET = 8'h00;
   localparam logic [7:0] IRQ_ROUTE_RESET = 8'h00;
   localparam logic [7:0] IRQ_ROUTE_MASK = 8'hF5;
   localparam logic [7:0] READ_IDLE = 8'h00;
   localparam int RST_SYNC_STAGES = 2;
   // selector field positions
   localparam int CS_SEL_LSB = 6;
   localparam int DIN_SEL_LSB = 4;
   localparam int SCK_SEL_LSB = 2;
   localparam int DOUT_SEL_LSB = 0;
   localparam int EXT_B_BIT = 7;
   localparam int EXT_A_BIT = 6;
   localparam int TMR_B_BIT = 5;
   localparam int TMR_A_BIT = 4;
   localparam int PIRQ_BIT = 2;
   localparam int PCLK_BIT = 0;
   // serial route codes
   typedef logic [1:0] ppr_route_t;
   localparam ppr_route_t ROUTE_PA = 2'h0;
   localparam ppr_route_t ROUTE_PC = 2'h1;
   localparam ppr_route_t ROUTE_PE = 2'h2;
   localparam ppr_route_t ROUTE_NONE = 2'h3;
   // pin positions per route
   localparam int CS_PA = 3;
   localparam int CS_PC = 3;
   localparam int CS_PE = 2;
   localparam int DIN_PA = 0;
   localparam int DIN_PC = 2;
   localparam int DIN_PE = 4;
   localparam int SCK_PA = 2;
   localparam int SCK_PC = 1;
   localparam int SCK_PE = 3;
   localparam int DOUT_PA = 7;
   localparam int DOUT_PC = 0;
   localparam int DOUT_PE = 5;
   localparam int EXT_B_PA = 1;
   localparam int EXT_B_PC = 5;
   localparam int EXT_A_PA = 4;
   localparam int EXT_A_PC = 4;
   localparam int TMR_B_PA = 1;
   localparam int TMR_B_PC = 5;
   localparam int TMR_A_PA = 4;
   localparam int TMR_A_PC = 4;
   localparam int PIRQ_PB = 5;
   localparam int PIRQ_PC = 7;
   localparam int PCLK_PB = 4;
   localparam int PCLK_PC = 6;
   // carriers
   typedef struct packed {
      logic [7:0] pa;
      logic [5:0] pb;
      logic [7:0] pc;
      logic [5:0] pe;
   } ppr_ports_s;
   typedef struct packed {
      logic chipSelOut;
      logic chipSelOe;
      logic sckOut;
      logic sckOe;
      logic sdoOut;
      logic sdoOe;
   } ppr_serial_drv_s;
   typedef struct packed {
      logic serialChipSelect;
      logic sdi;
      logic sck;
      logic extIrqA;
      logic extIrqB;
      logic timerAClk;
      logic timerBClk;
      logic periphIrq;
   } ppr_periph_in_s;
endpackage

// [hdl/ppr_pin_remap.sv]
// pin remap selection logic with its two route registers
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
//
// Contract
// [RL1] Chip select follows bits 7:6: 00 port A bit 3, 01 port C bit 3, 10 port E bit 2, 11 none.
// [RL2] Data in follows bits 5:4: 00 port A bit 0, 01 port C bit 2, 10 port E bit 4, 11 none.
// [RL3] Serial clock follows bits 3:2: 00 port A bit 2, 01 port C bit 1, 10 port E bit 3, 11 none.
// [RL4] Data out follows bits 1:0: 00 port A bit 7, 01 port C bit 0, 10 port E bit 5, 11 none.
// [RL5] Second register bit 7 takes external interrupt B from port A bit 1 or port C bit 5.
// [RL6] Second register bit 6 takes external interrupt A from port A bit 4 or port C bit 4.
// [RL7] Second register bit 5 takes timer B clock from port A bit 1 or port C bit 5.
// [RL8] Second register bit 4 takes timer A clock from port A bit 4 or port C bit 4.
// [RL9] Second register bit 2 takes the peripheral interrupt from port B bit 5 or port C bit 7.
// [RL10] Second register bit 0 puts the peripheral clock on port B bit 4 or port C bit 6.
// [RL11] Both registers clear at reset and second register bits 3 and 1 ignore writes, read zero.
module ppr_pin_remap (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register port
   input wire logic [ppr_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   // port pins
   input wire ppr_pkg::ppr_ports_s pinIn,
   output ppr_pkg::ppr_ports_s pinOut,
   output ppr_pkg::ppr_ports_s pinOe,
   // peripheral side
   input wire ppr_pkg::ppr_serial_drv_s serialDrv,
   input wire logic periphClk,
   output ppr_pkg::ppr_periph_in_s periphIn
);

   logic [ppr_pkg::RST_SYNC_STAGES-1:0] rstPipe_ff;
   logic rstSync_n;
   logic [7:0] serialRoute_ff;
   logic [7:0] irqRoute_ff;
   logic [7:0] regRdData_ff;
   ppr_pkg::ppr_ports_s pinMeta_ff;
   ppr_pkg::ppr_ports_s pinSync_ff;
   ppr_pkg::ppr_ports_s pinOut_ff;
   ppr_pkg::ppr_ports_s pinOe_ff;
   ppr_pkg::ppr_periph_in_s periphIn_ff;

   // reset release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstPipe_ff <= '0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[ppr_pkg::RST_SYNC_STAGES-2:0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_ff[ppr_pkg::RST_SYNC_STAGES-1];

   // register decode
   wire serialHit = (regAddr == ppr_pkg::SERIAL_ROUTE_ADDR);
   wire irqHit = (regAddr == ppr_pkg::IRQ_ROUTE_ADDR);
   wire [7:0] nxt_serialRoute = (regWrStb && serialHit) ? regWrData : serialRoute_ff;
   // unimplemented bits never store, so they read back zero
   wire [7:0] nxt_irqRoute = (regWrStb && irqHit) ? (regWrData & ppr_pkg::IRQ_ROUTE_MASK)
                                                  : irqRoute_ff; // RL11
   wire [7:0] readSel = serialHit ? serialRoute_ff : (irqHit ? irqRoute_ff : ppr_pkg::READ_IDLE);
   wire [7:0] nxt_regRdData = regRdStb ? readSel : ppr_pkg::READ_IDLE;

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         serialRoute_ff <= ppr_pkg::SERIAL_ROUTE_RESET; // RL11
         irqRoute_ff <= ppr_pkg::IRQ_ROUTE_RESET; // RL11
         regRdData_ff <= ppr_pkg::READ_IDLE;
      end else begin
         serialRoute_ff <= nxt_serialRoute;
         irqRoute_ff <= nxt_irqRoute;
         regRdData_ff <= nxt_regRdData;
      end
   end
   assign regRdData = regRdData_ff;

   // pin synchroniser, second stage is the only reader of the first
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pinMeta_ff <= '0;
         pinSync_ff <= '0;
      end else begin
         pinMeta_ff <= pinIn;
         pinSync_ff <= pinMeta_ff;
      end
   end

   // selector fields
   wire [1:0] csSel = serialRoute_ff[ppr_pkg::CS_SEL_LSB +: 2];
   wire [1:0] dinSel = serialRoute_ff[ppr_pkg::DIN_SEL_LSB +: 2];
   wire [1:0] sckSel = serialRoute_ff[ppr_pkg::SCK_SEL_LSB +: 2];
   wire [1:0] doutSel = serialRoute_ff[ppr_pkg::DOUT_SEL_LSB +: 2];
   wire extBSel = irqRoute_ff[ppr_pkg::EXT_B_BIT];
   wire extASel = irqRoute_ff[ppr_pkg::EXT_A_BIT];
   wire tmrBSel = irqRoute_ff[ppr_pkg::TMR_B_BIT];
   wire tmrASel = irqRoute_ff[ppr_pkg::TMR_A_BIT];
   wire pirqSel = irqRoute_ff[ppr_pkg::PIRQ_BIT];
   wire pclkSel = irqRoute_ff[ppr_pkg::PCLK_BIT];

   // inputs towards the peripherals; undefined code reads low
   wire csRouted = (csSel == ppr_pkg::ROUTE_PA) ? pinSync_ff.pa[ppr_pkg::CS_PA] :
                    (csSel == ppr_pkg::ROUTE_PC) ? pinSync_ff.pc[ppr_pkg::CS_PC] :
                    (csSel == ppr_pkg::ROUTE_PE) ? pinSync_ff.pe[ppr_pkg::CS_PE] :
                    1'b0; // RL1
   wire sdiRouted = (dinSel == ppr_pkg::ROUTE_PA) ? pinSync_ff.pa[ppr_pkg::DIN_PA] :
                    (dinSel == ppr_pkg::ROUTE_PC) ? pinSync_ff.pc[ppr_pkg::DIN_PC] :
                    (dinSel == ppr_pkg::ROUTE_PE) ? pinSync_ff.pe[ppr_pkg::DIN_PE] :
                    1'b0; // RL2
   wire sckRouted = (sckSel == ppr_pkg::ROUTE_PA) ? pinSync_ff.pa[ppr_pkg::SCK_PA] :
                    (sckSel == ppr_pkg::ROUTE_PC) ? pinSync_ff.pc[ppr_pkg::SCK_PC] :
                    (sckSel == ppr_pkg::ROUTE_PE) ? pinSync_ff.pe[ppr_pkg::SCK_PE] :
                    1'b0; // RL3
   wire extBRouted = extBSel ? pinSync_ff.pc[ppr_pkg::EXT_B_PC]
                             : pinSync_ff.pa[ppr_pkg::EXT_B_PA]; // RL5
   wire extARouted = extASel ? pinSync_ff.pc[ppr_pkg::EXT_A_PC]
                             : pinSync_ff.pa[ppr_pkg::EXT_A_PA]; // RL6
   wire tmrBRouted = tmrBSel ? pinSync_ff.pc[ppr_pkg::TMR_B_PC]
                             : pinSync_ff.pa[ppr_pkg::TMR_B_PA]; // RL7
   wire tmrARouted = tmrASel ? pinSync_ff.pc[ppr_pkg::TMR_A_PC]
                             : pinSync_ff.pa[ppr_pkg::TMR_A_PA]; // RL8
   wire pirqRouted = pirqSel ? pinSync_ff.pc[ppr_pkg::PIRQ_PC]
                             : pinSync_ff.pb[ppr_pkg::PIRQ_PB]; // RL9
   wire ppr_pkg::ppr_periph_in_s nxt_periphIn = '{serialChipSelect: csRouted, sdi: sdiRouted,
      sck: sckRouted, extIrqA: extARouted, extIrqB: extBRouted, timerAClk: tmrARouted,
      timerBClk: tmrBRouted, periphIrq: pirqRouted};

   // one-hot bit placement for the output side
   function automatic logic [7:0] place(input int idx, input logic en);
      logic [7:0] vec;
      vec = 8'h00;
      vec[idx] = en;
      return vec;
   endfunction

   // route enables per serial output
   wire csOnA = (csSel == ppr_pkg::ROUTE_PA) && serialDrv.chipSelOe;
   wire csOnC = (csSel == ppr_pkg::ROUTE_PC) && serialDrv.chipSelOe;
   wire csOnE = (csSel == ppr_pkg::ROUTE_PE) && serialDrv.chipSelOe;
   wire sckOnA = (sckSel == ppr_pkg::ROUTE_PA) && serialDrv.sckOe;
   wire sckOnC = (sckSel == ppr_pkg::ROUTE_PC) && serialDrv.sckOe;
   wire sckOnE = (sckSel == ppr_pkg::ROUTE_PE) && serialDrv.sckOe;
   wire doOnA = (doutSel == ppr_pkg::ROUTE_PA) && serialDrv.sdoOe;
   wire doOnC = (doutSel == ppr_pkg::ROUTE_PC) && serialDrv.sdoOe;
   wire doOnE = (doutSel == ppr_pkg::ROUTE_PE) && serialDrv.sdoOe;
   wire csO = serialDrv.chipSelOut;
   wire sckO = serialDrv.sckOut;
   wire doO = serialDrv.sdoOut;

   // drive pattern; the only output bits shared by two routes are disjoint by position
   wire [7:0] oeA = place(ppr_pkg::CS_PA, csOnA) | place(ppr_pkg::SCK_PA, sckOnA)
                  | place(ppr_pkg::DOUT_PA, doOnA); // RL1 RL3 RL4
   wire [7:0] oeB = place(ppr_pkg::PCLK_PB, !pclkSel); // RL10
   wire [7:0] oeC = place(ppr_pkg::CS_PC, csOnC) | place(ppr_pkg::SCK_PC, sckOnC)
                  | place(ppr_pkg::DOUT_PC, doOnC) | place(ppr_pkg::PCLK_PC, pclkSel);
   wire [7:0] oeE = place(ppr_pkg::CS_PE, csOnE) | place(ppr_pkg::SCK_PE, sckOnE)
                  | place(ppr_pkg::DOUT_PE, doOnE); // RL1 RL3 RL4
   wire [7:0] outA = place(ppr_pkg::CS_PA, csOnA && csO) | place(ppr_pkg::SCK_PA, sckOnA && sckO)
                   | place(ppr_pkg::DOUT_PA, doOnA && doO);
   wire [7:0] outB = place(ppr_pkg::PCLK_PB, !pclkSel && periphClk); // RL10
   wire [7:0] outC = place(ppr_pkg::CS_PC, csOnC && csO) | place(ppr_pkg::SCK_PC, sckOnC && sckO)
                   | place(ppr_pkg::DOUT_PC, doOnC && doO)
                   | place(ppr_pkg::PCLK_PC, pclkSel && periphClk); // RL10
   wire [7:0] outE = place(ppr_pkg::CS_PE, csOnE && csO) | place(ppr_pkg::SCK_PE, sckOnE && sckO)
                   | place(ppr_pkg::DOUT_PE, doOnE && doO);
   wire ppr_pkg::ppr_ports_s nxt_pinOe = '{pa: oeA, pb: oeB[5:0], pc: oeC, pe: oeE[5:0]};
   wire ppr_pkg::ppr_ports_s nxt_pinOut = '{pa: outA, pb: outB[5:0], pc: outC, pe: outE[5:0]};

   // registered pins cost a cycle but give glitch-free drive on selector change
   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pinOut_ff <= '0;
         pinOe_ff <= '0;
         periphIn_ff <= '0;
      end else begin
         pinOut_ff <= nxt_pinOut;
         pinOe_ff <= nxt_pinOe;
         periphIn_ff <= nxt_periphIn;
      end
   end
   assign pinOut = pinOut_ff;
   assign pinOe = pinOe_ff;
   assign periphIn = periphIn_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstSync_n);

   csInput_a: assert property ( // RL1
      $past(csSel) == ppr_pkg::ROUTE_PA
      |-> periphIn_ff.serialChipSelect == $past(pinSync_ff.pa[ppr_pkg::CS_PA]))
      else $error("chip select not taken from port A");
   csPortE_a: assert property ( // RL1
      $past(csSel == ppr_pkg::ROUTE_PE && serialDrv.chipSelOe) |-> pinOe_ff.pe[ppr_pkg::CS_PE]
      && pinOut_ff.pe[ppr_pkg::CS_PE] == $past(serialDrv.chipSelOut))
      else $error("chip select not driven on port E");
   csNone_a: assert property ( // RL1
      $past(csSel) == ppr_pkg::ROUTE_NONE
      |-> !periphIn_ff.serialChipSelect && !pinOe_ff.pa[ppr_pkg::CS_PA]
      && !pinOe_ff.pc[ppr_pkg::CS_PC] && !pinOe_ff.pe[ppr_pkg::CS_PE])
      else $error("undefined chip select code routes a pin");
   dinPortC_a: assert property ( // RL2
      $past(dinSel) == ppr_pkg::ROUTE_PC |-> periphIn_ff.sdi == $past(pinSync_ff.pc[ppr_pkg::DIN_PC]))
      else $error("data in not taken from port C");
   dinPortE_a: assert property ( // RL2
      $past(dinSel) == ppr_pkg::ROUTE_PE |-> periphIn_ff.sdi == $past(pinSync_ff.pe[ppr_pkg::DIN_PE]))
      else $error("data in not taken from port E");
   sckPortE_a: assert property ( // RL3
      $past(sckSel == ppr_pkg::ROUTE_PE) |-> pinOe_ff.pe[ppr_pkg::SCK_PE] == $past(serialDrv.sckOe)
      && periphIn_ff.sck == $past(pinSync_ff.pe[ppr_pkg::SCK_PE]))
      else $error("serial clock not on port E");
   doutPortC_a: assert property ( // RL4
      $past(doutSel == ppr_pkg::ROUTE_PC && serialDrv.sdoOe) |-> pinOe_ff.pc[ppr_pkg::DOUT_PC]
      && !pinOe_ff.pa[ppr_pkg::DOUT_PA] && pinOut_ff.pc[ppr_pkg::DOUT_PC] == $past(serialDrv.sdoOut))
      else $error("data out not on port C");
   extIrqB_a: assert property ( // RL5
      periphIn_ff.extIrqB == ($past(extBSel) ? $past(pinSync_ff.pc[ppr_pkg::EXT_B_PC])
                                             : $past(pinSync_ff.pa[ppr_pkg::EXT_B_PA])))
      else $error("external interrupt B on wrong pin");
   extIrqA_a: assert property ( // RL6
      periphIn_ff.extIrqA == ($past(extASel) ? $past(pinSync_ff.pc[ppr_pkg::EXT_A_PC])
                                             : $past(pinSync_ff.pa[ppr_pkg::EXT_A_PA])))
      else $error("external interrupt A on wrong pin");
   timerBClk_a: assert property ( // RL7
      periphIn_ff.timerBClk == ($past(tmrBSel) ? $past(pinSync_ff.pc[ppr_pkg::TMR_B_PC])
                                               : $past(pinSync_ff.pa[ppr_pkg::TMR_B_PA])))
      else $error("timer B clock on wrong pin");
   timerAClk_a: assert property ( // RL8
      periphIn_ff.timerAClk == ($past(tmrASel) ? $past(pinSync_ff.pc[ppr_pkg::TMR_A_PC])
                                               : $past(pinSync_ff.pa[ppr_pkg::TMR_A_PA])))
      else $error("timer A clock on wrong pin");
   periphIrq_a: assert property ( // RL9
      periphIn_ff.periphIrq == ($past(pirqSel) ? $past(pinSync_ff.pc[ppr_pkg::PIRQ_PC])
                                               : $past(pinSync_ff.pb[ppr_pkg::PIRQ_PB])))
      else $error("peripheral interrupt on wrong pin");
   periphClk_a: assert property ( // RL10
      $past(rstSync_n) |-> pinOe_ff.pc[ppr_pkg::PCLK_PC] == $past(pclkSel)
      && pinOe_ff.pb[ppr_pkg::PCLK_PB] == !$past(pclkSel)
      && (pinOut_ff.pc[ppr_pkg::PCLK_PC] | pinOut_ff.pb[ppr_pkg::PCLK_PB]) == $past(periphClk))
      else $error("peripheral clock on wrong pin");
   gapBits_a: assert property ( // RL11
      regWrStb && irqHit |=> irqRoute_ff == ($past(regWrData) & ppr_pkg::IRQ_ROUTE_MASK)
      ##1 irqRoute_ff[3] == 1'b0 && irqRoute_ff[1] == 1'b0)
      else $error("unimplemented route bits stored a write");
   readBack_a: assert property ( // RL11
      regRdStb |=> regRdData == (($past(serialHit)) ? $past(serialRoute_ff) :
                                 ($past(irqHit)) ? $past(irqRoute_ff) : ppr_pkg::READ_IDLE))
      else $error("read data mismatch");
   resetClear_a: assert property ( // RL11
      !$past(rstSync_n) |-> serialRoute_ff == ppr_pkg::SERIAL_ROUTE_RESET
      && irqRoute_ff == ppr_pkg::IRQ_ROUTE_RESET)
      else $error("route registers not clear after reset");

   // remaining codes; pins are still cleared on the edge the reset copy rises
   csPortA_a: assert property ( // RL1
      $past(rstSync_n) && $past(csSel) == ppr_pkg::ROUTE_PA
      |-> pinOe_ff.pa[ppr_pkg::CS_PA] == $past(serialDrv.chipSelOe)
      && !pinOe_ff.pe[ppr_pkg::CS_PE])
      else $error("chip select not driven on port A");
   csPortC_a: assert property ( // RL1
      $past(csSel) == ppr_pkg::ROUTE_PC
      |-> pinOe_ff.pc[ppr_pkg::CS_PC] == $past(serialDrv.chipSelOe)
      && periphIn_ff.serialChipSelect == $past(pinSync_ff.pc[ppr_pkg::CS_PC]))
      else $error("chip select not on port C");
   dinPortA_a: assert property ( // RL2
      $past(dinSel) == ppr_pkg::ROUTE_PA
      |-> periphIn_ff.sdi == $past(pinSync_ff.pa[ppr_pkg::DIN_PA]))
      else $error("data in not taken from port A");
   dinNone_a: assert property ( // RL2
      $past(dinSel) == ppr_pkg::ROUTE_NONE |-> !periphIn_ff.sdi)
      else $error("undefined data in code reads a pin");
   sckPortA_a: assert property ( // RL3
      $past(rstSync_n) && $past(sckSel) == ppr_pkg::ROUTE_PA
      |-> pinOe_ff.pa[ppr_pkg::SCK_PA] == $past(serialDrv.sckOe)
      && periphIn_ff.sck == $past(pinSync_ff.pa[ppr_pkg::SCK_PA]))
      else $error("serial clock not on port A");
   sckPortC_a: assert property ( // RL3
      $past(sckSel) == ppr_pkg::ROUTE_PC
      |-> pinOe_ff.pc[ppr_pkg::SCK_PC] == $past(serialDrv.sckOe)
      && periphIn_ff.sck == $past(pinSync_ff.pc[ppr_pkg::SCK_PC]))
      else $error("serial clock not on port C");
   sckNone_a: assert property ( // RL3
      $past(sckSel) == ppr_pkg::ROUTE_NONE |-> !periphIn_ff.sck && !pinOe_ff.pa[ppr_pkg::SCK_PA]
      && !pinOe_ff.pc[ppr_pkg::SCK_PC] && !pinOe_ff.pe[ppr_pkg::SCK_PE])
      else $error("undefined serial clock code routes a pin");
   doutPortA_a: assert property ( // RL4
      $past(rstSync_n) && $past(doutSel) == ppr_pkg::ROUTE_PA
      |-> pinOe_ff.pa[ppr_pkg::DOUT_PA] == $past(serialDrv.sdoOe)
      && pinOut_ff.pa[ppr_pkg::DOUT_PA] == $past(serialDrv.sdoOe && serialDrv.sdoOut))
      else $error("data out not on port A");
   doutPortE_a: assert property ( // RL4
      $past(doutSel) == ppr_pkg::ROUTE_PE
      |-> pinOe_ff.pe[ppr_pkg::DOUT_PE] == $past(serialDrv.sdoOe)
      && pinOut_ff.pe[ppr_pkg::DOUT_PE] == $past(serialDrv.sdoOe && serialDrv.sdoOut))
      else $error("data out not on port E");
   doutNone_a: assert property ( // RL4
      $past(doutSel) == ppr_pkg::ROUTE_NONE |-> !pinOe_ff.pa[ppr_pkg::DOUT_PA]
      && !pinOe_ff.pc[ppr_pkg::DOUT_PC] && !pinOe_ff.pe[ppr_pkg::DOUT_PE])
      else $error("undefined data out code drives a pin");
   readIdle_a: assert property ( // RL11
      !regRdStb |=> regRdData == ppr_pkg::READ_IDLE)
      else $error("read data not idle outside a read");

   csOnPortE_c: cover property (csSel == ppr_pkg::ROUTE_PE && serialDrv.chipSelOe
      ##1 pinOe_ff.pe[ppr_pkg::CS_PE]);
   undefCode_c: cover property (regWrStb && serialHit && regWrData == 8'hFF);
   pclkMove_c: cover property (!pclkSel ##1 pclkSel ##1 pinOe_ff.pc[ppr_pkg::PCLK_PC]);
   readIrqReg_c: cover property (regWrStb && irqHit ##1 regRdStb && irqHit);

endmodule

// [testbench/tb_ppr_pin_remap.sv]
// self-checking bench for the pin remap block: registers, input routing, output routing
`timescale 1ns/1ps
module tb_ppr_pin_remap;
   logic core_clk;
   logic reset_n;
   logic [ppr_pkg::REG_ADDR_W-1:0] regAddr;
   logic [7:0] regWrData;
   logic regWrStb;
   logic regRdStb;
   logic [7:0] regRdData;
   ppr_pkg::ppr_ports_s pinIn;
   ppr_pkg::ppr_ports_s pinOut;
   ppr_pkg::ppr_ports_s pinOe;
   ppr_pkg::ppr_serial_drv_s serialDrv;
   logic periphClk;
   ppr_pkg::ppr_periph_in_s periphIn;
   int failures;
   int total_checks;
   int cycles;
   integer seed;
   // pins that some route may drive: pa 7,3,2; pb 4; pc 6,3,1,0; pe 5,3,2
   localparam logic [27:0] ROUTED_PINS = {8'h8C, 6'h10, 8'h4B, 6'h2C};
   ppr_pin_remap ppr_pin_remap_inst (
      .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .serialDrv(serialDrv), .periphClk(periphClk),
      .periphIn(periphIn)
   );
   always #4 core_clk = ~core_clk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         failures = failures + 1;
      end
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      // sync copy rises on the 2nd edge, first request not before the 3rd
      repeat (3) @(posedge core_clk);
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrStb <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
      @(posedge core_clk);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      @(negedge core_clk);
      chk(nm, exp, regRdData);
      @(negedge core_clk);
      chk("read idle", ppr_pkg::READ_IDLE, regRdData);
   endtask
   function automatic logic rin(input logic [1:0] s, input logic a, input logic c, input logic e);
      // code 11 routes nothing and reads 0
      return (s == 2'h0) ? a : (s == 2'h1) ? c : (s == 2'h2) ? e : 1'b0;
   endfunction
   function automatic logic [7:0] dsel(input logic [1:0] s, input logic en);
      return {5'h00, s == 2'h2, s == 2'h1, s == 2'h0} & {8{en}};
   endfunction
   // drive fresh random pins and peripheral outputs, then let the 3-stage input path settle
   task automatic stir(output ppr_pkg::ppr_ports_s p, output ppr_pkg::ppr_serial_drv_s d);
      p = ppr_pkg::ppr_ports_s'($random(seed));
      d = ppr_pkg::ppr_serial_drv_s'($random(seed));
      @(posedge core_clk);
      pinIn <= p;
      serialDrv <= d;
      periphClk <= 1'($random(seed));
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic serial_case(input logic [7:0] s);
      ppr_pkg::ppr_ports_s p;
      ppr_pkg::ppr_serial_drv_s d;
      reg_wr(ppr_pkg::SERIAL_ROUTE_ADDR, s);
      reg_rd(ppr_pkg::SERIAL_ROUTE_ADDR, s, "serial route");
      stir(p, d);
      chk("cs in", 8'(rin(s[7:6], p.pa[3], p.pc[3], p.pe[2])),
          8'(periphIn.serialChipSelect));
      chk("cs oe", dsel(s[7:6], d.chipSelOe),
          {5'h00, pinOe.pe[2], pinOe.pc[3], pinOe.pa[3]});
      chk("cs out", dsel(s[7:6], d.chipSelOe & d.chipSelOut),
          {5'h00, pinOut.pe[2], pinOut.pc[3], pinOut.pa[3]});
      chk("sdi in", 8'(rin(s[5:4], p.pa[0], p.pc[2], p.pe[4])), 8'(periphIn.sdi));
      chk("sck in", 8'(rin(s[3:2], p.pa[2], p.pc[1], p.pe[3])), 8'(periphIn.sck));
      chk("sck oe", dsel(s[3:2], d.sckOe), {5'h00, pinOe.pe[3], pinOe.pc[1], pinOe.pa[2]});
      chk("sck out", dsel(s[3:2], d.sckOe & d.sckOut),
          {5'h00, pinOut.pe[3], pinOut.pc[1], pinOut.pa[2]});
      chk("sdo oe", dsel(s[1:0], d.sdoOe), {5'h00, pinOe.pe[5], pinOe.pc[0], pinOe.pa[7]});
      chk("sdo out", dsel(s[1:0], d.sdoOe & d.sdoOut),
          {5'h00, pinOut.pe[5], pinOut.pc[0], pinOut.pa[7]});
      chk("stray oe", 8'h00, 8'(|(pinOe & ~ROUTED_PINS)));
      chk("stray out", 8'h00, 8'(|(pinOut & ~ROUTED_PINS)));
   endtask
   task automatic irq_case(input logic [7:0] s);
      ppr_pkg::ppr_ports_s p;
      ppr_pkg::ppr_serial_drv_s d;
      reg_wr(ppr_pkg::IRQ_ROUTE_ADDR, s);
      reg_rd(ppr_pkg::IRQ_ROUTE_ADDR, s & 8'hF5, "irq route");
      stir(p, d);
      chk("ext b", 8'(s[7] ? p.pc[5] : p.pa[1]), 8'(periphIn.extIrqB));
      chk("ext a", 8'(s[6] ? p.pc[4] : p.pa[4]), 8'(periphIn.extIrqA));
      chk("timer b", 8'(s[5] ? p.pc[5] : p.pa[1]), 8'(periphIn.timerBClk));
      chk("timer a", 8'(s[4] ? p.pc[4] : p.pa[4]), 8'(periphIn.timerAClk));
      chk("periph irq", 8'(s[2] ? p.pc[7] : p.pb[5]), 8'(periphIn.periphIrq));
      chk("pclk oe", s[0] ? 8'h02 : 8'h01, {6'h00, pinOe.pc[6], pinOe.pb[4]});
      chk("pclk out", (s[0] ? 8'h02 : 8'h01) & {8{periphClk}},
          {6'h00, pinOut.pc[6], pinOut.pb[4]});
      chk("stray oe", 8'h00, 8'(|(pinOe & ~ROUTED_PINS)));
      chk("stray out", 8'h00, 8'(|(pinOut & ~ROUTED_PINS)));
   endtask
   initial begin
      core_clk = 1'b0;
      reset_n = 1'b0;
      regAddr = '0;
      regWrData = 8'h00;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      pinIn = '0;
      serialDrv = '0;
      periphClk = 1'b0;
      failures = 0;
      total_checks = 0;
      cycles = 0;
      seed = 32'h277d;
      do_reset();
      reg_rd(ppr_pkg::SERIAL_ROUTE_ADDR, 8'h00, "serial reset");
      reg_rd(ppr_pkg::IRQ_ROUTE_ADDR, 8'h00, "irq reset");
      reg_wr(4'h5, 8'hFF);
      reg_rd(4'h5, 8'h00, "unmapped");
      reg_rd(ppr_pkg::SERIAL_ROUTE_ADDR, 8'h00, "serial after unmapped");
      $display("test reset and decode done");
      // every code of every field first, then random selectors
      serial_case(8'h00);
      serial_case(8'h55);
      serial_case(8'hAA);
      serial_case(8'hFF);
      repeat (12) serial_case(8'($random(seed)));
      $display("test serial routing done");
      irq_case(8'hFF);
      irq_case(8'h00);
      irq_case(8'h0A);
      repeat (12) irq_case(8'($random(seed)));
      $display("test interrupt and timer routing done");
      // back-to-back write then read, then a reset in mid-run clears both
      @(posedge core_clk);
      regWrStb <= 1'b1;
      regAddr <= ppr_pkg::SERIAL_ROUTE_ADDR;
      regWrData <= 8'h9C;
      @(posedge core_clk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
      @(negedge core_clk);
      chk("back to back", 8'h9C, regRdData);
      reg_wr(ppr_pkg::IRQ_ROUTE_ADDR, 8'hF5);
      do_reset();
      reg_rd(ppr_pkg::SERIAL_ROUTE_ADDR, 8'h00, "serial rereset");
      reg_rd(ppr_pkg::IRQ_ROUTE_ADDR, 8'h00, "irq rereset");
      $display("test back to back and reset done");
      close_out();
   end
endmodule
